// file: common/lpd_pkg.sv
// Package for the panel power, contrast PWM and dithering register block.
package lpd_pkg;

   localparam logic [7:0]  LPD_OFS_FIFO_THRESHOLD  = 8'h00;
   localparam logic [7:0]  LPD_OFS_DP_HALF         = 8'h04;
   localparam logic [7:0]  LPD_OFS_DP_FOUR_SEVENTH = 8'h08;
   localparam logic [7:0]  LPD_OFS_DP_THREE_FIFTH  = 8'h0c;
   localparam logic [7:0]  LPD_OFS_DP_TWO_THIRD    = 8'h10;
   localparam logic [7:0]  LPD_OFS_DP_FIVE_SEVENTH = 8'h14;
   localparam logic [7:0]  LPD_OFS_DP_THREE_QUART  = 8'h18;
   localparam logic [7:0]  LPD_OFS_DP_FOUR_FIFTH   = 8'h1c;
   localparam logic [7:0]  LPD_OFS_DP_SIX_SEVENTH  = 8'h20;
   localparam logic [7:0]  LPD_OFS_POWER_SEQ       = 8'h24;
   localparam logic [7:0]  LPD_OFS_CONTRAST_CTRL   = 8'h28;
   localparam logic [7:0]  LPD_OFS_CONTRAST_VALUE  = 8'h2c;
   localparam logic [7:0]  LPD_OFS_SCAN_CONFIG     = 8'h30;

   localparam logic [15:0] LPD_RST_FIFO_TH  = 16'h0000;
   localparam logic [7:0]  LPD_RST_DP_1_2   = 8'ha5;
   localparam logic [27:0] LPD_RST_DP_4_7   = 28'h5af0fa5;
   localparam logic [19:0] LPD_RST_DP_3_5   = 20'ha5a5f;
   localparam logic [11:0] LPD_RST_DP_2_3   = 12'ha5f;
   localparam logic [27:0] LPD_RST_DP_5_7   = 28'hfaf5fa5;
   localparam logic [15:0] LPD_RST_DP_3_4   = 16'hfaf5;
   localparam logic [19:0] LPD_RST_DP_4_5   = 20'hfaf5f;
   localparam logic [27:0] LPD_RST_DP_6_7   = 28'hf5ffaff;
   localparam logic [6:0]  LPD_RST_GUARD    = 7'h07;
   localparam logic        LPD_RST_PWR_REQ  = 1'h0;
   localparam logic [7:0]  LPD_RST_CONTRAST_COMPARE_VALUE     = 8'h00;

   localparam int          LPD_POS_PWR_REQ  = 0;
   localparam int          LPD_POS_GUARD    = 1;
   localparam int          LPD_POS_BUSY     = 31;
   localparam int          LPD_POS_PS       = 0;
   localparam int          LPD_POS_POL      = 2;
   localparam int          LPD_POS_ENA      = 3;
   localparam int          LPD_POS_DUAL     = 0;
   localparam int          LPD_POS_EFF_SIZE = 16;

   localparam logic [9:0]  LPD_FIFO_WORDS   = 10'h200;

   typedef enum logic [3:0]
   {
      LPD_SEQ_OFF  = 4'b0001,
      LPD_SEQ_UP   = 4'b0010,
      LPD_SEQ_ON   = 4'b0100,
      LPD_SEQ_DOWN = 4'b1000
   } lpd_seq_t;

   function automatic logic [31:0] lpd_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : lpd_merge

endpackage : lpd_pkg

// file: common/lpd_pwm_if.sv
// Interface carrying contrast PWM settings and output between the two modules.
`timescale 1ns/1ps
interface lpd_pwm_if;
   logic [1:0] prescale;
   logic       polarity;
   logic       enable;
   logic [7:0] compare;
   logic       level;

   modport ctrl (output prescale, output polarity, output enable, output compare, input level);
   modport gen  (input prescale, input polarity, input enable, input compare, output level);
endinterface : lpd_pwm_if

// file: logic/lpd_contrast_pwm.sv
// Contrast PWM generator with prescaler, polarity and enable.
`timescale 1ns/1ps
module lpd_contrast_pwm
   import lpd_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   lpd_pwm_if.gen    pwm
);

   typedef struct packed
   {
      logic [2:0] pre;
      logic [7:0] cnt;
      logic       level;
   } lpd_pwm_state_t;

   lpd_pwm_state_t q;
   lpd_pwm_state_t d;
   logic [2:0]     last;

   assign pwm.level = q.level;

   always_comb
   begin
      d = q;
      last = 3'((4'd1 << pwm.prescale) - 4'd1);
      if (pwm.enable)
      begin
         if (q.pre >= last)
         begin
            d.pre = 3'h0;
            d.cnt = q.cnt + 8'h01;
         end
         else
         begin
            d.pre = q.pre + 3'h1;
         end
         d.level = pwm.polarity ? (q.cnt < pwm.compare) : !(q.cnt < pwm.compare);
      end
      else
      begin
         // Stopped generator parks at the inactive level so the filter sees no stray pulse.
         d.pre   = 3'h0;
         d.level = !pwm.polarity;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q       <= '0;
         // Polarity resets to 0, so the idle level is high; this avoids a low blip on the pin after reset.
         q.level <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : lpd_contrast_pwm

// file: logic/lpd_ctrl.sv
// Register block, panel power sequencer and contrast control of the display controller.
`timescale 1ns/1ps
module lpd_ctrl
   import lpd_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        FRAME_TICK,
   input  wire logic        DISPLAY_ACTIVE,
   output logic             PANEL_POWER,
   output logic             PANEL_CTRL_ENABLE,
   output logic             CONTRAST_PWM,
   output logic             DUAL_SCAN_MODE,
   output logic      [9:0]  FIFO_EFFECTIVE_SIZE,
   output logic      [15:0] FIFO_LEVEL_THRESHOLD,
   output logic      [7:0]  DITHER_HALF_PATTERN,
   output logic      [27:0] DITHER_FOUR_SEVENTHS_PATTERN,
   output logic      [19:0] DITHER_THREE_FIFTHS_PATTERN,
   output logic      [11:0] DITHER_TWO_THIRDS_PATTERN,
   output logic      [27:0] DITHER_FIVE_SEVENTHS_PATTERN,
   output logic      [15:0] DITHER_THREE_QUARTERS_PATTERN,
   output logic      [19:0] DITHER_FOUR_FIFTHS_PATTERN,
   output logic      [27:0] DITHER_SIX_SEVENTHS_PATTERN
);

   typedef struct packed
   {
      logic        ack;
      logic [31:0] rdata;
      logic [15:0] fifo_th;
      logic [7:0]  dp_1_2;
      logic [27:0] dp_4_7;
      logic [19:0] dp_3_5;
      logic [11:0] dp_2_3;
      logic [27:0] dp_5_7;
      logic [15:0] dp_3_4;
      logic [19:0] dp_4_5;
      logic [27:0] dp_6_7;
      logic        pwr_req;
      logic [6:0]  guard;
      lpd_seq_t    seq;
      logic [6:0]  frames;
      logic        panel_pwr;
      logic        ctrl_act;
      logic        busy;
      logic [1:0]  ps;
      logic        contrast_output_polarity;
      logic        ena;
      logic [7:0]  contrast_compare_value;
      logic        dual_scan;
      logic [9:0]  eff_size;
      logic        pwm_out;
   } lpd_ctrl_state_t;

   lpd_ctrl_state_t q;
   lpd_ctrl_state_t d;
   logic            rst_meta_q;
   logic            rst_sync_q;
   logic            access;
   logic            wr;
   logic [31:0]     cur;
   logic [31:0]     nxt;

   lpd_pwm_if pwm ();

   lpd_contrast_pwm u_pwm
   (
      .clk   (CLOCK),
      .rst_n (rst_sync_q),
      .pwm   (pwm)
   );

   assign pwm.prescale = q.ps;
   assign pwm.polarity = q.contrast_output_polarity;
   assign pwm.enable   = q.ena;
   assign pwm.compare  = q.contrast_compare_value;

   assign WB_DAT_O                      = q.rdata;
   assign WB_ACK_O                      = q.ack;
   assign PANEL_POWER                   = q.panel_pwr;
   assign PANEL_CTRL_ENABLE             = q.ctrl_act;
   assign CONTRAST_PWM                  = q.pwm_out;
   assign DUAL_SCAN_MODE                = q.dual_scan;
   assign FIFO_EFFECTIVE_SIZE           = q.eff_size;
   assign FIFO_LEVEL_THRESHOLD          = q.fifo_th;
   assign DITHER_HALF_PATTERN           = q.dp_1_2;
   assign DITHER_FOUR_SEVENTHS_PATTERN  = q.dp_4_7;
   assign DITHER_THREE_FIFTHS_PATTERN   = q.dp_3_5;
   assign DITHER_TWO_THIRDS_PATTERN     = q.dp_2_3;
   assign DITHER_FIVE_SEVENTHS_PATTERN  = q.dp_5_7;
   assign DITHER_THREE_QUARTERS_PATTERN = q.dp_3_4;
   assign DITHER_FOUR_FIFTHS_PATTERN    = q.dp_4_5;
   assign DITHER_SIX_SEVENTHS_PATTERN   = q.dp_6_7;

   // The reset is released synchronously so no flop leaves reset on a different edge.
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Current register image at the addressed offset, used for reads and byte merges.
   always_comb
   begin
      unique case (WB_ADR_I)
         LPD_OFS_FIFO_THRESHOLD  : cur = {16'h0000, q.fifo_th};
         LPD_OFS_DP_HALF         : cur = {24'h000000, q.dp_1_2};
         LPD_OFS_DP_FOUR_SEVENTH : cur = {4'h0, q.dp_4_7};
         LPD_OFS_DP_THREE_FIFTH  : cur = {12'h000, q.dp_3_5};
         LPD_OFS_DP_TWO_THIRD    : cur = {20'h00000, q.dp_2_3};
         LPD_OFS_DP_FIVE_SEVENTH : cur = {4'h0, q.dp_5_7};
         LPD_OFS_DP_THREE_QUART  : cur = {16'h0000, q.dp_3_4};
         LPD_OFS_DP_FOUR_FIFTH   : cur = {12'h000, q.dp_4_5};
         LPD_OFS_DP_SIX_SEVENTH  : cur = {4'h0, q.dp_6_7};
         LPD_OFS_POWER_SEQ       : cur = {q.busy, 23'h000000, q.guard, q.pwr_req};
         LPD_OFS_CONTRAST_CTRL   : cur = {28'h0000000, q.ena, q.contrast_output_polarity, q.ps};
         LPD_OFS_CONTRAST_VALUE  : cur = {24'h000000, q.contrast_compare_value};
         LPD_OFS_SCAN_CONFIG     : cur = {6'h00, q.eff_size, 15'h0000, q.dual_scan};
         default                 : cur = 32'h00000000;
      endcase
   end

   assign access = WB_CYC_I && WB_STB_I && !q.ack;
   assign wr     = access && WB_WE_I;
   assign nxt    = lpd_merge(cur, WB_DAT_I, WB_SEL_I);

   always_comb
   begin
      d = q;
      d.ack = access;
      if (access)
      begin
         d.rdata = cur;
      end
      if (wr)
      begin
         unique case (WB_ADR_I)
            LPD_OFS_FIFO_THRESHOLD  : d.fifo_th = nxt[15:0];
            LPD_OFS_DP_HALF         : d.dp_1_2 = nxt[7:0];
            LPD_OFS_DP_FOUR_SEVENTH : d.dp_4_7 = nxt[27:0];
            LPD_OFS_DP_THREE_FIFTH  : d.dp_3_5 = nxt[19:0];
            LPD_OFS_DP_TWO_THIRD    : d.dp_2_3 = nxt[11:0];
            LPD_OFS_DP_FIVE_SEVENTH : d.dp_5_7 = nxt[27:0];
            LPD_OFS_DP_THREE_QUART  : d.dp_3_4 = nxt[15:0];
            LPD_OFS_DP_FOUR_FIFTH   : d.dp_4_5 = nxt[19:0];
            LPD_OFS_DP_SIX_SEVENTH  : d.dp_6_7 = nxt[27:0];
            LPD_OFS_POWER_SEQ       :
            begin
               d.pwr_req = nxt[LPD_POS_PWR_REQ];
               d.guard   = nxt[LPD_POS_GUARD +: 7];
            end
            LPD_OFS_CONTRAST_CTRL   :
            begin
               d.ps  = nxt[LPD_POS_PS +: 2];
               d.contrast_output_polarity = nxt[LPD_POS_POL];
               d.ena = nxt[LPD_POS_ENA];
            end
            LPD_OFS_CONTRAST_VALUE  : d.contrast_compare_value = nxt[7:0];
            LPD_OFS_SCAN_CONFIG     : d.dual_scan = nxt[LPD_POS_DUAL];
            default                 : d.rdata = q.rdata;
         endcase
      end

      // effective FIFO size by scan mode
      d.eff_size = q.dual_scan ? (LPD_FIFO_WORDS >> 1) : LPD_FIFO_WORDS;

      // Power sequencer acts on the stored bit, so a write is seen one cycle after its ack edge.
      unique case (q.seq)
         LPD_SEQ_OFF :
         begin
            if (q.pwr_req)
            begin
               d.ctrl_act = 1'b1;
               d.frames   = 7'h00;
               d.seq      = LPD_SEQ_UP;
            end
         end
         LPD_SEQ_UP :
         begin
            if (!q.pwr_req)
            begin
               d.frames = 7'h00;
               d.seq    = LPD_SEQ_DOWN;
            end
            else if (q.frames >= q.guard)
            begin
               d.panel_pwr = 1'b1;
               d.seq       = LPD_SEQ_ON;
            end
            else if (FRAME_TICK)
            begin
               d.frames = q.frames + 7'h01;
            end
         end
         LPD_SEQ_ON :
         begin
            if (!q.pwr_req)
            begin
               d.panel_pwr = 1'b0;
               d.frames    = 7'h00;
               d.seq       = LPD_SEQ_DOWN;
            end
         end
         LPD_SEQ_DOWN :
         begin
            if (q.pwr_req)
            begin
               d.frames = 7'h00;
               d.seq    = LPD_SEQ_UP;
            end
            else if (q.frames >= q.guard)
            begin
               d.ctrl_act = 1'b0;
               d.seq      = LPD_SEQ_OFF;
            end
            else if (FRAME_TICK)
            begin
               d.frames = q.frames + 7'h01;
            end
         end
         default :
         begin
            d.panel_pwr = 1'b0;
            d.ctrl_act  = 1'b0;
            d.seq       = LPD_SEQ_OFF;
         end
      endcase

      d.busy    = DISPLAY_ACTIVE || (q.seq == LPD_SEQ_UP) || (q.seq == LPD_SEQ_DOWN);
      d.pwm_out = pwm.level;
   end

   always_ff @(posedge CLOCK or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         q           <= '0;
         q.fifo_th   <= LPD_RST_FIFO_TH;
         q.dp_1_2    <= LPD_RST_DP_1_2;
         q.dp_4_7    <= LPD_RST_DP_4_7;
         q.dp_3_5    <= LPD_RST_DP_3_5;
         q.dp_2_3    <= LPD_RST_DP_2_3;
         q.dp_5_7    <= LPD_RST_DP_5_7;
         q.dp_3_4    <= LPD_RST_DP_3_4;
         q.dp_4_5    <= LPD_RST_DP_4_5;
         q.dp_6_7    <= LPD_RST_DP_6_7;
         q.pwr_req   <= LPD_RST_PWR_REQ;
         q.guard     <= LPD_RST_GUARD;
         q.seq       <= LPD_SEQ_OFF;
         q.contrast_compare_value      <= LPD_RST_CONTRAST_COMPARE_VALUE;
         q.eff_size  <= LPD_FIFO_WORDS;
         q.pwm_out   <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : lpd_ctrl

// file: testbench/lpd_ctrl_monitor.sv
// Concurrent checks on the ports of the panel control block.
`timescale 1ns/1ps
module lpd_ctrl_monitor
   import lpd_pkg::*;
(
   input wire logic        CLOCK,
   input wire logic        RESETN,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        DISPLAY_ACTIVE,
   input wire logic        PANEL_POWER,
   input wire logic        PANEL_CTRL_ENABLE,
   input wire logic        DUAL_SCAN_MODE,
   input wire logic [9:0]  FIFO_EFFECTIVE_SIZE,
   input wire logic [7:0]  DITHER_HALF_PATTERN
);
   logic       take;
   logic       pwr_wr;
   logic [7:0] wlo_q;
   assign take   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign pwr_wr = take && WB_WE_I && WB_ADR_I == LPD_OFS_POWER_SEQ && WB_SEL_I[0];
   // Write data is kept so the pattern check can compare one cycle later.
   always_ff @(posedge CLOCK)
   begin
      wlo_q <= WB_DAT_I[7:0];
   end
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);
   ack_a: assert property (take |=> WB_ACK_O)
      else $error("ack missing after request");
   ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   pwr_order_a: assert property (PANEL_POWER |-> PANEL_CTRL_ENABLE)
      else $error("power on without control pins");
   pwr_up_a: assert property (pwr_wr && WB_DAT_I[0] |=> ##1 PANEL_CTRL_ENABLE)
      else $error("control pins late on power up");
   pwr_down_a: assert property (pwr_wr && !WB_DAT_I[0] |=> ##1 !PANEL_POWER)
      else $error("power pin late on power down");
   eff_size_a: assert property (FIFO_EFFECTIVE_SIZE == ($past(DUAL_SCAN_MODE) ? 10'h100 : 10'h200))
      else $error("effective fifo size wrong");
   busy_a: assert property (take && !WB_WE_I && WB_ADR_I == LPD_OFS_POWER_SEQ && DISPLAY_ACTIVE
                            && $past(DISPLAY_ACTIVE) |=> WB_DAT_O[31])
      else $error("busy clear while displaying");
   dither_half_a: assert property (take && WB_WE_I && WB_ADR_I == LPD_OFS_DP_HALF && WB_SEL_I[0]
                                   |=> DITHER_HALF_PATTERN == wlo_q)
      else $error("half pattern not written");
endmodule : lpd_ctrl_monitor

// file: testbench/lpd_panel_model.sv
// Panel model: frame pulse source and contrast filter integrator.
`timescale 1ns/1ps
module lpd_panel_model #(
   parameter int H_PIXELS = 10,
   parameter int LINES    = 4
) (
   input  wire logic clk,
   input  wire logic power,
   input  wire logic ctrl,
   input  wire logic pwm,
   output logic      frame_tick,
   output int        hi_cnt,
   output int        faults
);
   // Active-matrix horizontal size equals the pixel count.
   localparam logic active_matrix_mode    = 1'b1;
   localparam int   horizontal_size_field = active_matrix_mode ? H_PIXELS : 0;
   // One pixel per clock, so a frame lasts the horizontal size times the line count.
   localparam int   FRAME_CYC             = horizontal_size_field * LINES;
   int fcnt = 0;
   initial
   begin
      frame_tick = 1'b0;
      hi_cnt = 0;
      faults = 0;
   end
   always @(posedge clk)
   begin
      fcnt <= (fcnt == FRAME_CYC - 1) ? 0 : fcnt + 1;
      frame_tick <= (fcnt == FRAME_CYC - 1);
      if (pwm === 1'b1)
         hi_cnt <= hi_cnt + 1;
      if (power === 1'b1 && ctrl !== 1'b1)
         faults <= faults + 1;
   end
endmodule : lpd_panel_model

// file: testbench/lpd_ctrl_bench.sv
// Self-checking bench for the panel control block.
`timescale 1ns/1ps
module lpd_ctrl_bench;
   import lpd_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic        disp = 1'b0;
   logic [31:0] rdat, q;
   logic        ack, pwr, ctl, pwm, dual, ftick;
   logic [9:0]  eff;
   logic [7:0]  dhalf;
   logic [3:0]  sel = 4'hf;
   logic [15:0] fth, d34;
   logic [27:0] d47, d57, d67;
   logic [19:0] d35, d45;
   logic [11:0] d23;
   localparam int BURST = 4;
   int          fails = 0;
   int          cmp_count = 0;
   int          hi_cnt, faults, hi, ticks, n;
   logic [31:0] rstv [13] = '{32'h0, 32'ha5, 32'h5af0fa5, 32'ha5a5f, 32'ha5f, 32'hfaf5fa5, 32'hfaf5,
                              32'hfaf5f, 32'hf5ffaff, 32'he, 32'h0, 32'h0, 32'h2000000};
   logic [31:0] mask [9] = '{32'hffff, 32'hff, 32'hfffffff, 32'hfffff, 32'hfff, 32'hfffffff, 32'hffff,
                             32'hfffff, 32'hfffffff};
   always #10 clk = ~clk;
   lpd_ctrl dut (.CLOCK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .FRAME_TICK(ftick), .DISPLAY_ACTIVE(disp), .PANEL_POWER(pwr), .PANEL_CTRL_ENABLE(ctl),
      .CONTRAST_PWM(pwm), .DUAL_SCAN_MODE(dual), .FIFO_EFFECTIVE_SIZE(eff), .FIFO_LEVEL_THRESHOLD(fth),
      .DITHER_HALF_PATTERN(dhalf), .DITHER_FOUR_SEVENTHS_PATTERN(d47), .DITHER_THREE_FIFTHS_PATTERN(d35),
      .DITHER_TWO_THIRDS_PATTERN(d23), .DITHER_FIVE_SEVENTHS_PATTERN(d57), .DITHER_THREE_QUARTERS_PATTERN(d34),
      .DITHER_FOUR_FIFTHS_PATTERN(d45), .DITHER_SIX_SEVENTHS_PATTERN(d67));
   lpd_panel_model panel (.clk(clk), .power(pwr), .ctrl(ctl), .pwm(pwm), .frame_tick(ftick),
      .hi_cnt(hi_cnt), .faults(faults));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (ack !== 1'b1 && k < 50);
      if (k >= 50)
         fails++;
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // The guard count must not see a frame pulse near the write edge.
   task automatic after_tick;
      n = 0;
      while (ftick !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      repeat (5) @(posedge clk);
   endtask : after_tick
   task automatic wait_pin(input logic which, input logic lvl);
      ticks = 0;
      n = 0;
      while ((which ? ctl : pwr) !== lvl && n < 2000)
      begin
         @(posedge clk);
         if (ftick === 1'b1)
            ticks++;
         n++;
      end
      if (n >= 2000)
         fails++;
   endtask : wait_pin
   task automatic pwm_win(input logic [31:0] cv, input int len, input int exp);
      wb(8'h28, 1'b1, cv, q);
      repeat (20) @(posedge clk);
      hi = hi_cnt;
      repeat (len) @(posedge clk);
      chk("pwm high cycles", 32'(hi_cnt - hi), 32'(exp));
   endtask : pwm_win
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 13; i++)
      begin
         wb(8'(i * 4), 1'b0, 32'h0, q);
         chk("reset value", q, rstv[i]);
      end
      for (int i = 0; i < 9; i++)
      begin
         wb(8'(i * 4), 1'b1, 32'hffffffff, q);
         wb(8'(i * 4), 1'b0, 32'h0, q);
         chk("pattern width", q, mask[i]);
      end
      chk("half pattern pin", {24'h0, dhalf}, 32'hff);
      chk("threshold pin ones", {16'h0, fth}, 32'hffff);
      chk("four sevenths pin", {4'h0, d47}, 32'hfffffff);
      chk("five sevenths pin", {4'h0, d57}, 32'hfffffff);
      chk("six sevenths pin", {4'h0, d67}, 32'hfffffff);
      chk("three fifths pin", {12'h0, d35}, 32'hfffff);
      chk("four fifths pin", {12'h0, d45}, 32'hfffff);
      chk("two thirds pin", {20'h0, d23}, 32'hfff);
      chk("three quarters pin", {16'h0, d34}, 32'hffff);
      sel <= 4'h2;
      wb(8'h08, 1'b1, 32'h0, q);
      sel <= 4'hf;
      wb(8'h08, 1'b0, 32'h0, q);
      chk("byte merge", q, 32'hfff00ff);
      chk("byte merge pin", {4'h0, d47}, 32'hfff00ff);
      wb(8'h3c, 1'b1, 32'hffffffff, q);
      wb(8'h3c, 1'b0, 32'h0, q);
      chk("unmapped", q, 32'h0);
      wb(8'h30, 1'b1, 32'h1, q);
      wb(8'h30, 1'b0, 32'h0, q);
      chk("dual scan", q, 32'h1000001);
      chk("fifo size pin", {22'h0, eff}, 32'h100);
      chk("dual scan pin", {31'h0, dual}, 32'h1);
      wb(8'h30, 1'b1, 32'h0, q);
      wb(8'h00, 1'b1, 32'(512 - (2 * BURST + 3)), q);
      wb(8'h00, 1'b0, 32'h0, q);
      chk("threshold", q, 32'h1f5);
      chk("threshold pin", {16'h0, fth}, 32'h1f5);
      chk("single scan size pin", {22'h0, eff}, 32'h200);
      after_tick();
      wb(8'h24, 1'b1, 32'h5, q);
      wait_pin(1'b1, 1'b1);
      chk("power early", {31'h0, pwr}, 32'h0);
      wb(8'h24, 1'b0, 32'h0, q);
      chk("busy up", q, 32'h80000005);
      wait_pin(1'b0, 1'b1);
      chk("up frames", 32'(ticks), 32'h2);
      wb(8'h24, 1'b0, 32'h0, q);
      chk("idle on", q, 32'h5);
      after_tick();
      wb(8'h24, 1'b1, 32'h4, q);
      wait_pin(1'b0, 1'b0);
      chk("ctrl kept", {31'h0, ctl}, 32'h1);
      wb(8'h24, 1'b0, 32'h0, q);
      chk("busy down", q, 32'h80000004);
      wait_pin(1'b1, 1'b0);
      chk("down frames", 32'(ticks), 32'h2);
      disp <= 1'b1;
      repeat (3) @(posedge clk);
      wb(8'h24, 1'b0, 32'h0, q);
      chk("busy display", q, 32'h80000004);
      disp <= 1'b0;
      chk("panel faults", 32'(faults), 32'h0);
      wb(8'h2c, 1'b1, 32'h40, q);
      for (int p = 0; p < 4; p++)
      begin
         pwm_win(32'(12 + p), 256 << p, 64 << p);
      end
      pwm_win(32'h8, 256, 192);
      pwm_win(32'h4, 256, 0);
      pwm_win(32'h0, 256, 256);
      tally_and_finish();
   end
endmodule : lpd_ctrl_bench
bind lpd_ctrl lpd_ctrl_monitor u_mon (.CLOCK(CLOCK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .DISPLAY_ACTIVE(DISPLAY_ACTIVE), .PANEL_POWER(PANEL_POWER),
   .PANEL_CTRL_ENABLE(PANEL_CTRL_ENABLE), .DUAL_SCAN_MODE(DUAL_SCAN_MODE),
   .FIFO_EFFECTIVE_SIZE(FIFO_EFFECTIVE_SIZE), .DITHER_HALF_PATTERN(DITHER_HALF_PATTERN));
